// File: logic/cfg_port_front.sv
// Index/data port front end: latches the index, turns data strobes into accesses.
// Assumes port strobes are one-cycle pulses synchronous to core_clk.
`timescale 1ns/1ns
`include "unit_cfg_consts.svh"
module cfg_port_front
(
  input  wire logic                    core_clk,
  input  wire logic                    resetn,
  // Host ports
  input  wire logic                    cfg_mode,
  input  wire logic                    index_wr,
  input  wire logic                    data_wr,
  input  wire logic                    data_rd,
  input  wire unit_cfg_pkg::cfg_byte_t host_wdata,
  output      unit_cfg_pkg::cfg_byte_t index_q,
  // Toward the bank
  cfg_access_if.front                  acc
);
  unit_cfg_pkg::cfg_byte_t index_reg;
  unit_cfg_pkg::cfg_byte_t index_next;

  always_comb
  begin
    index_next = index_reg;
    if (cfg_mode && index_wr)
    begin
      index_next = host_wdata;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      index_reg <= `RST_ZERO;
    end
    else
    begin
      index_reg <= index_next;
    end
  end

  // Outside configuration state no strobe reaches the bank; index and wdata still pass through
  assign acc.wr_stb = cfg_mode & data_wr;
  assign acc.rd_stb = cfg_mode & data_rd;
  assign acc.index  = index_reg;
  assign acc.wdata  = host_wdata;
  assign index_q    = index_reg;
endmodule

// File: logic/unit_cfg_bank.sv
// Banked per-unit configuration registers behind an index/data port pair.
// Assumes one clock, async active-low reset; soft and bus resets are ORed in outside
// or through soft_reset here. Strobes are synchronous one-cycle pulses.
//
// Behaviour
// - Eight banks; bank-number register at 0x07 picks the bank for 0x30 upward.
// - Host writes index port, then data port accesses reach that register.
// - Per-unit registers reachable only while in configuration state.
// - Activation bit 0 at 0x30 enables selected unit; bits 7:1 reserved.
// - Indices 0x31 to 0x5F ignore writes and read zero.
// - Primary base address: 0x60 high byte, 0x61 low byte.
// - Secondary base address from 0x62 high and 0x63 low when needed.
// - Unused base registers in 0x60 to 0x6F ignore writes, read zero.
// - Every unit has interrupt select at 0x70.
// - Second interrupt select 0x72 exists only for keyboard unit.
// - Indices 0x71 and 0x73 ignore writes and read zero.
// - After reset interrupt outputs are active-high edge requests.
// - Unit is on when activation or power bit set; bits linked.
// - Base outside the unit's permitted window makes unit's I/O invalid.
// - Interrupt select 0x70 resets to 0x06 for unit 0, else zero.
`timescale 1ns/1ns
`include "unit_cfg_consts.svh"
module unit_cfg_bank #(
  parameter int UNITS = 8
)
(
  input  wire logic                    core_clk,
  input  wire logic                    resetn,
  // Resets beyond power-on: soft reset and standby supply clear
  input  wire logic                    soft_reset,
  input  wire logic                    standby_supply_power_on_clear,
  // Host index/data ports
  input  wire logic                    cfg_mode,
  input  wire logic                    index_wr,
  input  wire logic                    data_wr,
  input  wire logic                    data_rd,
  input  wire unit_cfg_pkg::cfg_byte_t host_wdata,
  output      unit_cfg_pkg::cfg_byte_t host_rdata,
  // Power control bits from each unit's own power logic
  input  wire logic [UNITS-1:0]        power_ctrl_set,
  input  wire logic [UNITS-1:0]        power_ctrl_clr,
  // Per-unit results
  output      logic [UNITS-1:0]        unit_on,
  output      logic [UNITS-1:0]        io_valid,
  output      logic [UNITS*16-1:0]     base_pri,
  output      logic [UNITS*16-1:0]     base_sec,
  output      logic [UNITS*8-1:0]      irq_pri,
  output      logic [UNITS*8-1:0]      irq_sec,
  output      logic [UNITS-1:0]        irq_active_high,
  output      logic [UNITS-1:0]        irq_edge_mode,
  output      logic [2:0]              selected_unit
);
  initial
  begin
    if (UNITS != 8)
    begin
      $error("unit_cfg_bank serves exactly eight units");
    end
    if (int'(`UNIT_KEYBOARD) >= UNITS)
    begin
      $error("unit_cfg_bank keyboard unit number lies outside the bank");
    end
    if (int'(`UNIT_PARALLEL) >= UNITS)
    begin
      $error("unit_cfg_bank parallel unit number lies outside the bank");
    end
  end

  cfg_access_if acc ();
  unit_cfg_pkg::cfg_byte_t index_q;

  cfg_port_front u_front
  (
    .core_clk   (core_clk),
    .resetn     (resetn),
    .cfg_mode   (cfg_mode),
    .index_wr   (index_wr),
    .data_wr    (data_wr),
    .data_rd    (data_rd),
    .host_wdata (host_wdata),
    .index_q    (index_q),
    .acc        (acc)
  );

  // Which units have a secondary base pair: only the parallel unit here
  function automatic logic has_sec_base(input int u);
    has_sec_base = (u == int'(`UNIT_PARALLEL));
  endfunction

  // Units with relocatable primary base; keyboard is fixed
  function automatic logic has_pri_base(input int u);
    has_pri_base = (u != int'(`UNIT_KEYBOARD));
  endfunction

  function automatic logic base_in_window(input logic [15:0] a);
    base_in_window = (a >= `BASE_WINDOW_LO) && (a <= `BASE_WINDOW_HI);
  endfunction

  function automatic unit_cfg_pkg::cfg_byte_t irq_pri_reset(input int u);
    irq_pri_reset = (u == 0) ? `RST_IRQ_PRI_UNIT0 : `RST_ZERO;
  endfunction

  // Power-on contents of one unit; shared by the async reset and the synchronous clears
  function automatic unit_cfg_pkg::unit_regs_t unit_reset_value(input int u);
    unit_cfg_pkg::unit_regs_t r;
    r         = '0;
    r.irq_pri = irq_pri_reset(u);
    unit_reset_value = r;
  endfunction

  // Whether an index holds a real register in unit u; anything else reads as zero
  function automatic logic reg_present(input unit_cfg_pkg::cfg_byte_t idx, input int u);
    logic present;
    present = 1'b0;
    unique case (idx)
      `IDX_BANK_SELECT:
      begin
        present = 1'b1;
      end
      `IDX_ACTIVATION:
      begin
        present = 1'b1;
      end
      `IDX_IRQ_PRI:
      begin
        present = 1'b1;
      end
      `IDX_BASE_HI_PRI,
      `IDX_BASE_LO_PRI:
      begin
        present = has_pri_base(u);
      end
      `IDX_BASE_HI_SEC,
      `IDX_BASE_LO_SEC:
      begin
        present = has_sec_base(u);
      end
      `IDX_IRQ_SEC:
      begin
        present = (u == int'(`UNIT_KEYBOARD));
      end
      default:
      begin
        present = 1'b0;
      end
    endcase
    reg_present = present;
  endfunction

  unit_cfg_pkg::cfg_byte_t    bank_sel_reg;
  unit_cfg_pkg::cfg_byte_t    bank_sel_next;
  unit_cfg_pkg::unit_regs_t   regs_reg  [UNITS];
  unit_cfg_pkg::unit_regs_t   regs_next [UNITS];
  unit_cfg_pkg::cfg_byte_t    rdata_reg;
  unit_cfg_pkg::cfg_byte_t    rdata_next;
  unit_cfg_pkg::port_state_t  state_reg;
  unit_cfg_pkg::port_state_t  state_next;
  logic                       clear_all;
  unit_cfg_pkg::unit_num_t    sel;

  assign clear_all = soft_reset | standby_supply_power_on_clear;
  // Bank number only uses its low bits; upper units alias
  assign sel           = bank_sel_reg[2:0];
  assign selected_unit = sel;

  // Bank register write and per-unit register writes
  always_comb
  begin
    bank_sel_next = bank_sel_reg;
    for (int u = 0; u < UNITS; u++)
    begin
      regs_next[u] = regs_reg[u];
      // Power bit and activation bit move together
      if (power_ctrl_set[u])
      begin
        regs_next[u].activation[`ACT_BIT] = 1'b1;
      end
      else if (power_ctrl_clr[u])
      begin
        regs_next[u].activation[`ACT_BIT] = 1'b0;
      end
    end
    if (acc.wr_stb)
    begin
      if (acc.index == `IDX_BANK_SELECT)
      begin
        bank_sel_next = acc.wdata;
      end
      // Host write beats a same-cycle power change on the selected unit
      unique case (acc.index)
        `IDX_ACTIVATION:
        begin
          regs_next[sel].activation = {7'h00, acc.wdata[`ACT_BIT]};
        end
        `IDX_BASE_HI_PRI:
        begin
          if (has_pri_base(int'(sel)))
          begin
            regs_next[sel].base_hi_pri = acc.wdata;
          end
        end
        `IDX_BASE_LO_PRI:
        begin
          if (has_pri_base(int'(sel)))
          begin
            regs_next[sel].base_lo_pri = acc.wdata;
          end
        end
        `IDX_BASE_HI_SEC:
        begin
          if (has_sec_base(int'(sel)))
          begin
            regs_next[sel].base_hi_sec = acc.wdata;
          end
        end
        `IDX_BASE_LO_SEC:
        begin
          if (has_sec_base(int'(sel)))
          begin
            regs_next[sel].base_lo_sec = acc.wdata;
          end
        end
        `IDX_IRQ_PRI:
        begin
          regs_next[sel].irq_pri = acc.wdata;
        end
        `IDX_IRQ_SEC:
        begin
          if (sel == `UNIT_KEYBOARD)
          begin
            regs_next[sel].irq_sec = acc.wdata;
          end
        end
        // Everything else in 0x31-0x5F, 0x64-0x6F, 0x71, 0x73 is dropped
        default:
        begin
          bank_sel_next = bank_sel_next;
        end
      endcase
    end
    // Soft and standby clears win over a host or power-bit change in the same cycle
    if (clear_all)
    begin
      bank_sel_next = `RST_BANK_SELECT;
      for (int u = 0; u < UNITS; u++)
      begin
        regs_next[u] = unit_reset_value(u);
      end
    end
  end

  // Registers only: every next-value decision, clears included, sits in the process above
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bank_sel_reg <= `RST_BANK_SELECT;
      for (int u = 0; u < UNITS; u++)
      begin
        regs_reg[u] <= unit_reset_value(u);
      end
    end
    else
    begin
      bank_sel_reg <= bank_sel_next;
      for (int u = 0; u < UNITS; u++)
      begin
        regs_reg[u] <= regs_next[u];
      end
    end
  end

  // Read path: the data byte is captured on the read strobe, valid next cycle
  always_comb
  begin
    rdata_next = rdata_reg;
    state_next = unit_cfg_pkg::PORT_IDLE;
    if (acc.rd_stb)
    begin
      state_next = unit_cfg_pkg::PORT_READ;
      unique case (acc.index)
        `IDX_BANK_SELECT: rdata_next = bank_sel_reg;
        `IDX_ACTIVATION:  rdata_next = regs_reg[sel].activation;
        `IDX_BASE_HI_PRI: rdata_next = regs_reg[sel].base_hi_pri;
        `IDX_BASE_LO_PRI: rdata_next = regs_reg[sel].base_lo_pri;
        `IDX_BASE_HI_SEC: rdata_next = regs_reg[sel].base_hi_sec;
        `IDX_BASE_LO_SEC: rdata_next = regs_reg[sel].base_lo_sec;
        `IDX_IRQ_PRI:     rdata_next = regs_reg[sel].irq_pri;
        `IDX_IRQ_SEC:     rdata_next = regs_reg[sel].irq_sec;
        default:          rdata_next = `RST_ZERO;
      endcase
      // Fields a unit does not back read zero whatever the storage holds
      if (!reg_present(acc.index, int'(sel)))
      begin
        rdata_next = `RST_ZERO;
      end
    end
    else if (acc.wr_stb)
    begin
      state_next = unit_cfg_pkg::PORT_WRITE;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rdata_reg <= `RST_ZERO;
      state_reg <= unit_cfg_pkg::PORT_IDLE;
    end
    else
    begin
      rdata_reg <= rdata_next;
      state_reg <= state_next;
    end
  end

  assign acc.rdata  = rdata_reg;
  assign host_rdata = rdata_reg;

  // Per-unit decoded outputs
  always_comb
  begin
    logic [15:0] pri;
    pri = '0;
    for (int u = 0; u < UNITS; u++)
    begin
      pri = {regs_reg[u].base_hi_pri, regs_reg[u].base_lo_pri};
      unit_on[u]          = regs_reg[u].activation[`ACT_BIT];
      // Fixed-base keyboard unit is always decodable when on
      io_valid[u]         = regs_reg[u].activation[`ACT_BIT]
                            & (!has_pri_base(u) | base_in_window(pri));
      base_pri[u*16 +: 16] = pri;
      base_sec[u*16 +: 16] = {regs_reg[u].base_hi_sec, regs_reg[u].base_lo_sec};
      irq_pri[u*8 +: 8]    = regs_reg[u].irq_pri;
      irq_sec[u*8 +: 8]    = regs_reg[u].irq_sec;
      // No polarity or type bits are held here, so the reset convention always applies
      irq_active_high[u]   = 1'b1;
      irq_edge_mode[u]     = 1'b1;
    end
  end
endmodule

// File: shared/cfg_access_if.sv
// Carries one decoded register access from the port front end to the bank.
// Single clock; the front end drives, the bank answers from a register one cycle after the read strobe.
`timescale 1ns/1ns
interface cfg_access_if;
  logic                     wr_stb;
  logic                     rd_stb;
  unit_cfg_pkg::cfg_byte_t  index;
  unit_cfg_pkg::cfg_byte_t  wdata;
  unit_cfg_pkg::cfg_byte_t  rdata;

  modport front
  (
    output wr_stb,
    output rd_stb,
    output index,
    output wdata,
    input  rdata
  );
  modport bank
  (
    input  wr_stb,
    input  rd_stb,
    input  index,
    input  wdata,
    output rdata
  );
endinterface

// File: shared/unit_cfg_consts.svh
// Constants for the per-unit configuration bank: indices, resets, unit numbers.
// Included by the design files; holds definitions only.
`ifndef UNIT_CFG_CONSTS_SVH
`define UNIT_CFG_CONSTS_SVH

`define IDX_BANK_SELECT       8'h07
`define IDX_ACTIVATION        8'h30
`define IDX_BASE_HI_PRI       8'h60
`define IDX_BASE_LO_PRI       8'h61
`define IDX_BASE_HI_SEC       8'h62
`define IDX_BASE_LO_SEC       8'h63
`define IDX_BASE_RANGE_LO     8'h60
`define IDX_BASE_RANGE_HI     8'h6f
`define IDX_IRQ_PRI           8'h70
`define IDX_IRQ_SEC           8'h72
`define IDX_BANK_FIRST        8'h30

`define ACT_BIT               0
`define RST_ZERO              8'h00
`define RST_IRQ_PRI_UNIT0     8'h06
`define RST_BANK_SELECT       8'h00

`define UNIT_KEYBOARD         3'h7
`define UNIT_PARALLEL         3'h3

// Permitted primary base window, in bytes
`define BASE_WINDOW_LO        16'h0100
`define BASE_WINDOW_HI        16'h0ff8

`endif

// File: shared/unit_cfg_pkg.sv
// Types shared by the configuration bank and its access port.
// Assumes unit_cfg_consts.svh is on the include path.
package unit_cfg_pkg;
  typedef logic [7:0] cfg_byte_t;
  typedef logic [2:0] unit_num_t;

  typedef struct packed {
    cfg_byte_t activation;
    cfg_byte_t base_hi_pri;
    cfg_byte_t base_lo_pri;
    cfg_byte_t base_hi_sec;
    cfg_byte_t base_lo_sec;
    cfg_byte_t irq_pri;
    cfg_byte_t irq_sec;
  } unit_regs_t;

  // Access port sequencing
  typedef enum logic [1:0] {
    PORT_IDLE  = 2'b00,
    PORT_WRITE = 2'b01,
    PORT_READ  = 2'b11
  } port_state_t;
endpackage

// File: verif/cfg_host_model.sv
// Host model of the index/data port pair, driven by the bench through tasks.
// Assumes strobes are sampled on the rising edge of core_clk.
`timescale 1ns/1ns
module cfg_host_model
(
  // Clock
  input  wire logic        core_clk,
  // Port strobes and data
  output      logic        cfg_mode,
  output      logic        index_wr,
  output      logic        data_wr,
  output      logic        data_rd,
  output      logic [7:0]  host_wdata
);
  initial
  begin
    cfg_mode = 1'b0;
    {data_rd, data_wr, index_wr} = 3'b000;
    host_wdata = 8'h00;
  end
  // k is {read, data write, index write}: one strobe cycle, then release
  task automatic put(input logic [2:0] k, input logic [7:0] d);
    @(posedge core_clk);
    {data_rd, data_wr, index_wr} <= k;
    host_wdata <= d;
    @(posedge core_clk);
    {data_rd, data_wr, index_wr} <= 3'b000;
    // Released bus shows a new value so a stale byte cannot pass
    host_wdata <= ~d;
  endtask
  task automatic mode(input logic m);
    @(posedge core_clk);
    cfg_mode <= m;
  endtask
endmodule

// File: verif/unit_cfg_bank_props.sv
// Checker for the per-unit configuration bank.
// Assumes eight units and one clock domain.
`timescale 1ns/1ns
module unit_cfg_bank_props #(
  parameter int UNITS = 8
)
(
  // Clock and resets
  input wire logic                core_clk,
  input wire logic                resetn,
  input wire logic                soft_reset,
  input wire logic                standby_supply_power_on_clear,
  // Host side
  input wire logic                cfg_mode,
  input wire logic                data_wr,
  input wire logic                data_rd,
  input wire logic [7:0]          host_rdata,
  input wire logic [UNITS-1:0]    power_ctrl_set,
  input wire logic [UNITS-1:0]    power_ctrl_clr,
  // Unit results
  input wire logic [UNITS-1:0]    unit_on,
  input wire logic [UNITS-1:0]    io_valid,
  input wire logic [UNITS*16-1:0] base_pri,
  input wire logic [UNITS*16-1:0] base_sec,
  input wire logic [UNITS*8-1:0]  irq_pri,
  input wire logic [UNITS*8-1:0]  irq_sec,
  input wire logic [UNITS-1:0]    irq_active_high,
  input wire logic [UNITS-1:0]    irq_edge_mode,
  input wire logic [2:0]          selected_unit
);
  wire logic clr = soft_reset | standby_supply_power_on_clear;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  property p_rd_hold;
    !data_rd && !clr |=> $stable(host_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_gate;
    !cfg_mode && !clr |=> $stable(selected_unit) && $stable(irq_pri) && $stable(base_pri);
  endproperty
  a_gate: assert property (p_gate) else $error("change outside config");
  property p_irq_mode;
    irq_active_high == 8'hff && irq_edge_mode == 8'hff;
  endproperty
  a_irq_mode: assert property (p_irq_mode) else $error("irq mode");
  property p_pwr;
    !data_wr && !clr && power_ctrl_set != 8'h00
      |=> (unit_on & $past(power_ctrl_set)) == $past(power_ctrl_set);
  endproperty
  a_pwr: assert property (p_pwr) else $error("power bit not linked");
  property p_pwr_clr;
    !data_wr && !clr && power_ctrl_clr != 8'h00 && power_ctrl_set == 8'h00
      |=> (unit_on & $past(power_ctrl_clr)) == 8'h00;
  endproperty
  a_pwr_clr: assert property (p_pwr_clr) else $error("power clear not linked");
  property p_valid;
    io_valid[0] == (unit_on[0] && base_pri[15:0] >= 16'h0100 && base_pri[15:0] <= 16'h0ff8);
  endproperty
  a_valid: assert property (p_valid) else $error("io valid");
  property p_kbd_base;
    base_pri[127:112] == 16'h0000;
  endproperty
  a_kbd_base: assert property (p_kbd_base) else $error("kbd base");
  property p_sec;
    base_sec[47:0] == 48'h0 && base_sec[127:64] == 64'h0;
  endproperty
  a_sec: assert property (p_sec) else $error("unused sec base");
  property p_irq_sec;
    irq_sec[55:0] == 56'h0;
  endproperty
  a_irq_sec: assert property (p_irq_sec) else $error("unused irq2");
  property p_clear;
    clr |=> irq_pri[7:0] == 8'h06 && irq_pri[63:8] == 56'h0 && selected_unit == 3'h0;
  endproperty
  a_clear: assert property (p_clear) else $error("clear values");

  c_read: cover property (cfg_mode && data_rd);
  c_clear: cover property (clr);
  c_valid: cover property (io_valid[3]);
endmodule

bind unit_cfg_bank unit_cfg_bank_props #(.UNITS(UNITS)) u_props (
  .core_clk(core_clk), .resetn(resetn), .soft_reset(soft_reset),
  .standby_supply_power_on_clear(standby_supply_power_on_clear),
  .cfg_mode(cfg_mode), .data_wr(data_wr), .data_rd(data_rd), .host_rdata(host_rdata),
  .power_ctrl_set(power_ctrl_set), .power_ctrl_clr(power_ctrl_clr),
  .unit_on(unit_on), .io_valid(io_valid),
  .base_pri(base_pri), .base_sec(base_sec), .irq_pri(irq_pri), .irq_sec(irq_sec),
  .irq_active_high(irq_active_high), .irq_edge_mode(irq_edge_mode),
  .selected_unit(selected_unit));

// File: verif/unit_cfg_bank_tb.sv
// Self-checking bench for the per-unit configuration bank.
// Host accesses go through cfg_host_model; expectations follow the register map.
`timescale 1ns/1ns
module unit_cfg_bank_tb;
  logic          core_clk, resetn, soft_reset, standby_supply_power_on_clear;
  logic          cfg_mode, index_wr, data_wr, data_rd;
  logic [7:0]    host_wdata, host_rdata, power_ctrl_set, power_ctrl_clr;
  logic [7:0]    unit_on, io_valid;
  logic [127:0]  base_pri, base_sec;
  logic [63:0]   irq_pri, irq_sec;
  logic [2:0]    selected_unit;
  int            mismatches = 0, cmp_count = 0, cyc = 0;

  cfg_host_model u_host (.core_clk(core_clk), .cfg_mode(cfg_mode), .index_wr(index_wr),
    .data_wr(data_wr), .data_rd(data_rd), .host_wdata(host_wdata));
  unit_cfg_bank #(.UNITS(8)) u_dut (.core_clk(core_clk), .resetn(resetn),
    .soft_reset(soft_reset), .standby_supply_power_on_clear(standby_supply_power_on_clear),
    .cfg_mode(cfg_mode), .index_wr(index_wr), .data_wr(data_wr), .data_rd(data_rd),
    .host_wdata(host_wdata), .host_rdata(host_rdata), .power_ctrl_set(power_ctrl_set),
    .power_ctrl_clr(power_ctrl_clr), .unit_on(unit_on), .io_valid(io_valid),
    .base_pri(base_pri), .base_sec(base_sec), .irq_pri(irq_pri), .irq_sec(irq_sec),
    .irq_active_high(), .irq_edge_mode(), .selected_unit(selected_unit));

  task automatic ck(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    u_host.put(3'b001, i);
    u_host.put(3'b010, d);
  endtask
  task automatic rc(input string n, input logic [7:0] i, input logic [7:0] e);
    u_host.put(3'b001, i);
    u_host.put(3'b100, 8'h00);
    @(negedge core_clk);
    ck(n, {8'h00, e}, {8'h00, host_rdata});
  endtask

  task automatic t_reset_values;
    rc("irq unit0", 8'h70, 8'h06);
    rc("activation", 8'h30, 8'h00);
    wr(8'h07, 8'h01);
    rc("irq unit1", 8'h70, 8'h00);
  endtask
  task automatic t_banks;
    for (int u = 0; u < 8; u++)
    begin
      wr(8'h07, 8'(u));
      wr(8'h70, 8'h20 + 8'(u));
    end
    for (int u = 7; u >= 0; u--)
    begin
      wr(8'h07, 8'(u));
      rc("irq select", 8'h70, 8'h20 + 8'(u));
      ck("irq out", {8'h00, 8'h20 + 8'(u)}, {8'h00, irq_pri[u*8 +: 8]});
    end
  endtask
  task automatic t_base;
    logic [7:0] d [4] = '{8'h01, 8'h00, 8'h02, 8'h04};
    wr(8'h07, 8'h03);
    foreach (d[i])
      wr(8'h60 + 8'(i), d[i]);
    wr(8'h30, 8'hff);
    @(negedge core_clk);
    ck("base pri", 16'h0100, base_pri[63:48]);
    ck("base sec", 16'h0204, base_sec[63:48]);
    ck("io valid", 16'h0001, {15'h0, io_valid[3]});
    rc("activation", 8'h30, 8'h01);
    wr(8'h60, 8'h10);
    @(negedge core_clk);
    ck("io valid", 16'h0000, {15'h0, io_valid[3]});
    wr(8'h07, 8'h07);
    wr(8'h60, 8'h01);
    rc("kbd base", 8'h60, 8'h00);
  endtask
  task automatic t_reserved;
    logic [7:0] idx [10] = '{8'h31, 8'h37, 8'h38, 8'h3f, 8'h40, 8'h5f,
      8'h64, 8'h6f, 8'h71, 8'h73};
    wr(8'h07, 8'h00);
    foreach (idx[i])
    begin
      wr(idx[i], 8'hff);
      rc("reserved", idx[i], 8'h00);
    end
    wr(8'h72, 8'h5a);
    rc("irq2 unit0", 8'h72, 8'h00);
    wr(8'h07, 8'h07);
    wr(8'h72, 8'h5a);
    rc("irq2 kbd", 8'h72, 8'h5a);
    ck("irq2 out", 16'h005a, {8'h00, irq_sec[63:56]});
  endtask
  task automatic t_gate;
    u_host.put(3'b001, 8'h70);
    u_host.mode(1'b0);
    u_host.put(3'b100, 8'h00);
    @(negedge core_clk);
    ck("gated read", 16'h005a, {8'h00, host_rdata});
    wr(8'h70, 8'h99);
    wr(8'h07, 8'h00);
    u_host.mode(1'b1);
    @(negedge core_clk);
    ck("unit sel", 16'h0007, {13'h0, selected_unit});
    u_host.put(3'b100, 8'h00);
    @(negedge core_clk);
    ck("gated index", 16'h0027, {8'h00, host_rdata});
    rc("irq unit7", 8'h70, 8'h27);
  endtask
  task automatic t_power;
    @(posedge core_clk);
    power_ctrl_set <= 8'h20;
    @(posedge core_clk);
    power_ctrl_set <= 8'h00;
    wr(8'h07, 8'h05);
    rc("linked act", 8'h30, 8'h01);
    ck("unit on", 16'h0001, {15'h0, unit_on[5]});
    @(posedge core_clk);
    power_ctrl_clr <= 8'h20;
    @(posedge core_clk);
    power_ctrl_clr <= 8'h00;
    rc("linked clear", 8'h30, 8'h00);
    ck("unit off", 16'h0000, {15'h0, unit_on[5]});
  endtask
  task automatic t_clear;
    for (int k = 0; k < 2; k++)
    begin
      wr(8'h07, 8'h00);
      wr(8'h70, 8'h0f);
      wr(8'h07, 8'h02);
      @(posedge core_clk);
      soft_reset <= (k == 0);
      standby_supply_power_on_clear <= (k == 1);
      @(posedge core_clk);
      soft_reset <= 1'b0;
      standby_supply_power_on_clear <= 1'b0;
      @(negedge core_clk);
      ck("sel cleared", 16'h0000, {13'h0, selected_unit});
      rc("irq cleared", 8'h70, 8'h06);
    end
  endtask

  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // Whole run needs about 400 cycles
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      mismatches++;
      report_and_stop;
    end
  end
  initial
  begin
    resetn = 1'b0;
    soft_reset = 1'b0;
    standby_supply_power_on_clear = 1'b0;
    power_ctrl_set = 8'h00;
    power_ctrl_clr = 8'h00;
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    u_host.mode(1'b1);
    t_reset_values;
    t_banks;
    t_base;
    t_reserved;
    t_gate;
    t_power;
    t_clear;
    report_and_stop;
  end
endmodule
